// File: rtl/ccf_filter.sv
// cycle counter filter register, access decode and count qualifier
// Summary of operation
// - 64-bit register, reserved bits read zero
// - low word shared by all views
// - privileged bit set stops secure EL1 counting
// - user bit set stops secure EL0 counting
// - nonsecure EL1 counts when kernel bits match
// - nonsecure EL0 counts when user bits match
// - nonsecure EL2 counts when hypervisor bit set
// - secure EL3 counts when monitor bit matches
// - secure EL2 counts when hypervisor bits differ
// - transactional bit stops non-transactional counting
// - realm EL1 counts when kernel bits match
// - realm EL0 counts when user bits match
// - realm EL2 counts when hypervisor bits differ
// - absent features' fields read as zero
// - window register reaches filter at selector 31
// - decode the filter system-register encoding
// - EL0 without user enable traps
// - fine-grained trap bits trap to EL2
// - EL2 monitor trap bit traps to EL2
// - EL3 monitor trap, or undefined halted
// - EL3 access is never trapped
// - no monitor feature means undefined
`timescale 1ns/10ps
`default_nettype none
module ccf_filter
   import ccf_pkg::*;
#(
   parameter bit HAS_PMU = 1'b1,
   parameter bit HAS_EL2 = 1'b1,
   parameter bit HAS_EL3 = 1'b1,
   parameter bit HAS_SEL2 = 1'b1,
   parameter bit HAS_TME = 1'b1,
   parameter bit HAS_REALM = 1'b1,
   parameter bit EL3_TRAP_PRIO = 1'b1
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // processor state
   input wire logic [1:0] cur_el,
   input wire logic [1:0] cur_sec,
   input wire logic in_transaction,
   input wire logic halted,
   input wire logic el2_enabled,
   input wire logic sel2_enabled,
   // system register access
   input wire logic sys_valid,
   input wire logic sys_write,
   input wire logic [1:0] sys_op0,
   input wire logic [2:0] sys_op1,
   input wire logic [3:0] sys_crn,
   input wire logic [3:0] sys_crm,
   input wire logic [2:0] sys_op2,
   input wire logic sys_window,
   input wire logic [4:0] counter_selector_field,
   input wire logic [63:0] sys_wdata,
   // 32-bit and external debug views
   input wire logic alt_write,
   input wire logic [31:0] alt_wdata,
   // trap controls
   input wire logic user_access_enable_bit,
   input wire logic host_trap_general_bit,
   input wire logic host_el2_bit,
   input wire logic fine_grained_trap_permit,
   input wire logic fine_grained_read_trap,
   input wire logic fine_grained_write_trap,
   input wire logic el2_monitor_trap_bit,
   input wire logic el3_monitor_trap_bit,
   input wire logic secure_debug_disabled,
   // results
   output logic sys_done,
   output logic [63:0] sys_rdata,
   output logic [2:0] sys_outcome,
   output logic [5:0] sys_syndrome_class,
   output logic [31:0] alt_rdata,
   output logic count_enable
);
   logic [31:0] filt_r, filt_nxt;
   logic done_r, done_nxt;
   logic [63:0] rdata_r, rdata_nxt;
   logic [2:0] outc_r, outc_nxt;
   logic [5:0] ec_r, ec_nxt;
   logic cnt_r, cnt_nxt;
   logic hit;
   logic [31:0] impl_mask;
   logic [31:0] view;
   logic ok;
   logic c;
   ccf_outcome_type outcome;

   ccf_access_check u_check (
      .cur_el(cur_el),
      .halted(halted),
      .is_write(sys_write),
      .pmu_present(HAS_PMU),
      .el2_enabled(el2_enabled),
      .el3_present(HAS_EL3),
      .user_access_enable_bit(user_access_enable_bit),
      .host_trap_general_bit(host_trap_general_bit),
      .host_el2_bit(host_el2_bit),
      .fine_grained_trap_permit(fine_grained_trap_permit),
      .fine_grained_read_trap(fine_grained_read_trap),
      .fine_grained_write_trap(fine_grained_write_trap),
      .el2_monitor_trap_bit(el2_monitor_trap_bit),
      .el3_monitor_trap_bit(el3_monitor_trap_bit),
      .secure_debug_disabled(secure_debug_disabled),
      .el3_trap_priority(EL3_TRAP_PRIO),
      .outcome(outcome)
   );

   always_comb begin
      impl_mask = 32'h0;
      impl_mask[CCF_BIT_P] = 1'b1;
      impl_mask[CCF_BIT_U] = 1'b1;
      impl_mask[CCF_BIT_NS_KERNEL] = HAS_EL3;
      impl_mask[CCF_BIT_NS_USER] = HAS_EL3;
      impl_mask[CCF_BIT_HYP] = HAS_EL2;
      impl_mask[CCF_BIT_M] = HAS_EL3;
      impl_mask[CCF_BIT_SEC_HYP] = HAS_SEL2 && HAS_EL3 && sel2_enabled;
      impl_mask[CCF_BIT_T] = HAS_TME;
      impl_mask[CCF_BIT_REALM_KERNEL] = HAS_REALM;
      impl_mask[CCF_BIT_REALM_USER] = HAS_REALM;
      impl_mask[CCF_BIT_REALM_HYP] = HAS_REALM;
      // bits 25 and 19:0 never implemented, upper word absent
      view = filt_r & impl_mask;
      hit = sys_valid && ((sys_op0 == CCF_OP0 && sys_op1 == CCF_OP1 && sys_crn == CCF_CRN
         && sys_crm == CCF_CRM && sys_op2 == CCF_OP2)
         || (sys_window && counter_selector_field == CCF_SEL_CYCLE));
      ok = (outcome == CCF_OK);
      filt_nxt = filt_r;
      if (hit && ok && sys_write) begin
         filt_nxt = sys_wdata[31:0] & impl_mask;
      end else if (alt_write) begin
         filt_nxt = alt_wdata & impl_mask;
      end
      done_nxt = hit;
      rdata_nxt = (hit && ok && !sys_write) ? {32'h0, view} : 64'h0;
      outc_nxt = hit ? outcome : CCF_OK;
      ec_nxt = (hit && (outcome == CCF_TRAP_EL1 || outcome == CCF_TRAP_EL2
         || outcome == CCF_TRAP_EL3)) ? CCF_EC_SYSREG : 6'h0;
   end

   // count qualifier, one term per exception level
   always_comb begin
      c = 1'b0;
      case (cur_el)
         // in nonsecure and realm state the match alone decides, so a set base bit can still count
         2'h0: begin
            c = !view[CCF_BIT_U];
            if (cur_sec == 2'h1 && HAS_EL3) begin
               c = view[CCF_BIT_NS_USER] == view[CCF_BIT_U];
            end else if (cur_sec == 2'h2 && HAS_REALM) begin
               c = view[CCF_BIT_REALM_USER] == view[CCF_BIT_U];
            end
         end
         2'h1: begin
            c = !view[CCF_BIT_P];
            if (cur_sec == 2'h1 && HAS_EL3) begin
               c = view[CCF_BIT_NS_KERNEL] == view[CCF_BIT_P];
            end else if (cur_sec == 2'h2 && HAS_REALM) begin
               c = view[CCF_BIT_REALM_KERNEL] == view[CCF_BIT_P];
            end
         end
         2'h2: begin
            c = HAS_EL2 && view[CCF_BIT_HYP];
            if (cur_sec == 2'h0 && HAS_SEL2 && HAS_EL3) begin
               c = view[CCF_BIT_SEC_HYP] != view[CCF_BIT_HYP];
            end else if (cur_sec == 2'h2 && HAS_REALM) begin
               c = view[CCF_BIT_REALM_HYP] != view[CCF_BIT_HYP];
            end
         end
         default: begin
            c = HAS_EL3 && (view[CCF_BIT_M] == view[CCF_BIT_P]);
         end
      endcase
      // T set suppresses counting outside a transaction
      if (HAS_TME && view[CCF_BIT_T] && !in_transaction) begin
         c = 1'b0;
      end
      cnt_nxt = HAS_PMU && c;
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         filt_r <= CCF_RESET_VAL;
         done_r <= 1'b0;
         rdata_r <= 64'h0;
         outc_r <= 3'h0;
         ec_r <= 6'h0;
         cnt_r <= 1'b0;
      end else begin
         filt_r <= filt_nxt;
         done_r <= done_nxt;
         rdata_r <= rdata_nxt;
         outc_r <= outc_nxt;
         ec_r <= ec_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // debug view read registered, zero in unimplemented fields
   logic [31:0] alt_r;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         alt_r <= 32'h0;
      end else begin
         alt_r <= view;
      end
   end

   assign sys_done = done_r;
   assign sys_rdata = rdata_r;
   assign sys_outcome = outc_r;
   assign sys_syndrome_class = ec_r;
   assign alt_rdata = alt_r;
   assign count_enable = cnt_r;

   a_upper_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
      sys_rdata[63:32] == 32'h0 && alt_rdata[19:0] == 20'h0 && !alt_rdata[25])
      else $error("reserved filter bits nonzero");
   a_el0_user: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (cur_el == 2'h0 && cur_sec == 2'h0 && view[CCF_BIT_U]) |=> !count_enable)
      else $error("counted in secure EL0 with user bit set");
   a_el1_priv: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (cur_el == 2'h1 && cur_sec == 2'h0 && view[CCF_BIT_P]) |=> !count_enable)
      else $error("counted in secure EL1 with privileged bit set");
   a_ns_kernel: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (cur_el == 2'h1 && cur_sec == 2'h1 && HAS_EL3
       && view[CCF_BIT_NS_KERNEL] != view[CCF_BIT_P]) |=> !count_enable)
      else $error("nonsecure EL1 counted despite mismatch");
   a_ns_user: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (cur_el == 2'h0 && cur_sec == 2'h1 && HAS_EL3
       && view[CCF_BIT_NS_USER] != view[CCF_BIT_U]) |=> !count_enable)
      else $error("nonsecure EL0 counted despite mismatch");
   a_el2_hyp: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (cur_el == 2'h2 && cur_sec == 2'h1 && view[CCF_BIT_T] == 1'b0)
      |=> count_enable == $past(view[CCF_BIT_HYP]))
      else $error("EL2 count does not follow hypervisor bit");
   a_sec_hyp: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (cur_el == 2'h2 && cur_sec == 2'h0 && HAS_SEL2 && HAS_EL3
       && view[CCF_BIT_SEC_HYP] == view[CCF_BIT_HYP]) |=> !count_enable)
      else $error("secure EL2 counted with equal hypervisor bits");
   a_realm_kernel: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (cur_el == 2'h1 && cur_sec == 2'h2 && HAS_REALM
       && view[CCF_BIT_REALM_KERNEL] != view[CCF_BIT_P]) |=> !count_enable)
      else $error("realm EL1 counted despite mismatch");
   a_realm_user: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (cur_el == 2'h0 && cur_sec == 2'h2 && HAS_REALM
       && view[CCF_BIT_REALM_USER] != view[CCF_BIT_U]) |=> !count_enable)
      else $error("realm EL0 counted despite mismatch");
   a_realm_hyp: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (cur_el == 2'h2 && cur_sec == 2'h2 && HAS_REALM
       && view[CCF_BIT_REALM_HYP] == view[CCF_BIT_HYP]) |=> !count_enable)
      else $error("realm EL2 counted with equal hypervisor bits");
   a_el3_mon: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (cur_el == 2'h3 && view[CCF_BIT_M] != view[CCF_BIT_P]) |=> !count_enable)
      else $error("EL3 counted despite mismatch");
   a_ntx_stop: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (view[CCF_BIT_T] && !in_transaction) |=> !count_enable)
      else $error("counted outside transaction with T set");
   a_user_trap: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (hit && cur_el == 2'h0 && !user_access_enable_bit && !halted)
      |=> sys_done && sys_syndrome_class == CCF_EC_SYSREG && sys_outcome != 3'h0)
      else $error("EL0 access without enable not trapped");
   a_el3_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (hit && sys_write && cur_el == 2'h3 && !alt_write)
      |=> filt_r == ($past(sys_wdata[31:0]) & $past(impl_mask)) && sys_outcome == 3'h0)
      else $error("EL3 write not stored");
   a_mon2_trap: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (hit && cur_el == 2'h1 && el2_enabled && el2_monitor_trap_bit && !halted)
      |=> sys_outcome == 3'(CCF_TRAP_EL2))
      else $error("EL2 monitor trap missed");

   // answers shared by the trap and undefined checks
   sequence s_trap_answer;
      sys_done && sys_syndrome_class == CCF_EC_SYSREG;
   endsequence
   sequence s_plain_answer;
      sys_done && sys_syndrome_class == 6'h0;
   endsequence
   a_fine_trap: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (hit && HAS_PMU && cur_el == 2'h1 && !halted && el2_enabled
       && (!HAS_EL3 || fine_grained_trap_permit)
       && (sys_write ? fine_grained_write_trap : fine_grained_read_trap))
      |=> s_trap_answer ##0 sys_outcome == 3'(CCF_TRAP_EL2))
      else $error("fine-grained trap missed");
   a_halt_undef: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (hit && HAS_PMU && HAS_EL3 && EL3_TRAP_PRIO && cur_el != 2'h3 && halted
       && secure_debug_disabled && el3_monitor_trap_bit)
      |=> s_plain_answer ##0 sys_outcome == 3'(CCF_UNDEF))
      else $error("halted access with secure debug off not undefined");
   a_mon3_trap: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (hit && HAS_PMU && HAS_EL3 && cur_el == 2'h2 && !halted && el3_monitor_trap_bit)
      |=> s_trap_answer ##0 sys_outcome == 3'(CCF_TRAP_EL3))
      else $error("EL3 monitor trap missed");
   a_refused_store: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (hit && sys_write && outcome != CCF_OK && !alt_write) |=> $stable(filt_r))
      else $error("refused write changed the filter");
   a_done_follow: assert property (@(posedge clk_sys) disable iff (!reset_n)
      hit |=> sys_done)
      else $error("taken request not answered");
endmodule : ccf_filter
`default_nettype wire

// File: rtl/ccf_pkg.sv
// package: constants for the cycle counter mode filter
package ccf_pkg;
   localparam int CCF_BIT_P = 31;
   localparam int CCF_BIT_U = 30;
   localparam int CCF_BIT_NS_KERNEL = 29;
   localparam int CCF_BIT_NS_USER = 28;
   localparam int CCF_BIT_HYP = 27;
   localparam int CCF_BIT_M = 26;
   localparam int CCF_BIT_SEC_HYP = 24;
   localparam int CCF_BIT_T = 23;
   localparam int CCF_BIT_REALM_KERNEL = 22;
   localparam int CCF_BIT_REALM_USER = 21;
   localparam int CCF_BIT_REALM_HYP = 20;
   localparam logic [31:0] CCF_RESET_VAL = 32'h0000_0000;
   localparam logic [1:0] CCF_OP0 = 2'h3;
   localparam logic [2:0] CCF_OP1 = 3'h3;
   localparam logic [3:0] CCF_CRN = 4'he;
   localparam logic [3:0] CCF_CRM = 4'hf;
   localparam logic [2:0] CCF_OP2 = 3'h7;
   localparam logic [4:0] CCF_SEL_CYCLE = 5'h1f;
   localparam logic [5:0] CCF_EC_SYSREG = 6'h18;
   typedef enum logic [1:0] {CCF_EL0, CCF_EL1, CCF_EL2, CCF_EL3} ccf_el_type;
   typedef enum logic [1:0] {CCF_SEC, CCF_NONSEC, CCF_REALM, CCF_ROOT} ccf_sec_type;
   typedef enum logic [2:0] {CCF_OK, CCF_UNDEF, CCF_TRAP_EL1, CCF_TRAP_EL2,
      CCF_TRAP_EL3} ccf_outcome_type;
endpackage : ccf_pkg

// File: rtl/ccf_access_check.sv
// access permission check for one system-register access
`timescale 1ns/10ps
`default_nettype none
module ccf_access_check
   import ccf_pkg::*;
(
   // state
   input wire logic [1:0] cur_el,
   input wire logic halted,
   input wire logic is_write,
   input wire logic pmu_present,
   input wire logic el2_enabled,
   input wire logic el3_present,
   // trap controls
   input wire logic user_access_enable_bit,
   input wire logic host_trap_general_bit,
   input wire logic host_el2_bit,
   input wire logic fine_grained_trap_permit,
   input wire logic fine_grained_read_trap,
   input wire logic fine_grained_write_trap,
   input wire logic el2_monitor_trap_bit,
   input wire logic el3_monitor_trap_bit,
   input wire logic secure_debug_disabled,
   input wire logic el3_trap_priority,
   // result
   output var ccf_outcome_type outcome
);
   logic fgt;
   logic mon3;
   always_comb begin
      fgt = el2_enabled && (!el3_present || fine_grained_trap_permit)
         && (is_write ? fine_grained_write_trap : fine_grained_read_trap);
      mon3 = el3_present && el3_monitor_trap_bit;
      outcome = CCF_OK;
      if (!pmu_present) begin
         outcome = CCF_UNDEF;
      end else if (cur_el == 2'h3) begin
         outcome = CCF_OK;
      end else if (halted && secure_debug_disabled && el3_trap_priority && mon3) begin
         outcome = CCF_UNDEF;
      end else if (cur_el == 2'h0 && !user_access_enable_bit) begin
         outcome = (el2_enabled && host_trap_general_bit) ? CCF_TRAP_EL2 : CCF_TRAP_EL1;
      end else if (cur_el != 2'h2 && fgt
            && !(cur_el == 2'h0 && host_el2_bit && host_trap_general_bit)) begin
         outcome = CCF_TRAP_EL2;
      end else if (cur_el != 2'h2 && el2_enabled && el2_monitor_trap_bit) begin
         outcome = CCF_TRAP_EL2;
      end else if (mon3) begin
         outcome = (halted && secure_debug_disabled) ? CCF_UNDEF : CCF_TRAP_EL3;
      end
   end
endmodule : ccf_access_check
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the cycle counter filter block
`timescale 1ns/10ps
`default_nettype none
module testbench
   import ccf_pkg::*;
();
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic [1:0] cur_el = 2'h3;
   logic [1:0] cur_sec = 2'h1;
   logic in_transaction = 1'b1, halted = 1'b0, el2_enabled = 1'b1, sel2_enabled = 1'b1;
   logic sys_valid = 1'b0, sys_write = 1'b0, sys_window = 1'b0, alt_write = 1'b0;
   logic [1:0] sys_op0 = CCF_OP0;
   logic [2:0] sys_op1 = CCF_OP1, sys_op2 = CCF_OP2;
   logic [3:0] sys_crn = CCF_CRN, sys_crm = CCF_CRM;
   logic [4:0] counter_selector_field = 5'h00;
   logic [63:0] sys_wdata = 64'h0;
   logic [31:0] alt_wdata = 32'h0;
   logic user_access_enable_bit = 1'b1, host_trap_general_bit = 1'b0, host_el2_bit = 1'b0;
   logic fine_grained_trap_permit = 1'b1, fine_grained_read_trap = 1'b0;
   logic fine_grained_write_trap = 1'b0, el2_monitor_trap_bit = 1'b0;
   logic el3_monitor_trap_bit = 1'b0, secure_debug_disabled = 1'b0;
   logic sys_done, count_enable;
   logic [63:0] sys_rdata;
   logic [2:0] sys_outcome;
   logic [5:0] sys_syndrome_class;
   logic [31:0] alt_rdata;
   int miscompares = 0;
   int num_checks = 0;

   ccf_filter dut (.clk_sys, .reset_n, .cur_el, .cur_sec, .in_transaction, .halted,
      .el2_enabled, .sel2_enabled, .sys_valid, .sys_write, .sys_op0, .sys_op1, .sys_crn,
      .sys_crm, .sys_op2, .sys_window, .counter_selector_field, .sys_wdata, .alt_write,
      .alt_wdata, .user_access_enable_bit, .host_trap_general_bit, .host_el2_bit,
      .fine_grained_trap_permit, .fine_grained_read_trap, .fine_grained_write_trap,
      .el2_monitor_trap_bit, .el3_monitor_trap_bit, .secure_debug_disabled, .sys_done,
      .sys_rdata, .sys_outcome, .sys_syndrome_class, .alt_rdata, .count_enable);

   always #2.5 clk_sys = ~clk_sys;

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // one request; hit low means the block must ignore it
   task automatic acc(input logic [1:0] el, input logic wr, input logic [63:0] wd,
         input logic [2:0] oc, input logic [63:0] rd, input logic hit);
      int n;
      n = 0;
      @(posedge clk_sys);
      cur_el <= el;
      sys_valid <= 1'b1;
      sys_write <= wr;
      sys_wdata <= wd;
      @(posedge clk_sys);
      sys_valid <= 1'b0;
      #1;
      while (sys_done !== 1'b1 && n < 4) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (!hit) chk(64'(n), 64'h4);
      else if (n == 4) begin
         miscompares++;
         $display("wrong value at %0t: no completion", $time);
         tally_and_finish();
      end else begin
         chk(64'(sys_outcome), 64'(oc));
         chk(64'(sys_syndrome_class), (oc > 3'h1) ? 64'(CCF_EC_SYSREG) : 64'h0);
         chk(sys_rdata, rd);
      end
   endtask : acc

   // program the filter at the top level, then move to the given state
   task automatic ce(input logic [31:0] f, input logic [1:0] el, input logic [1:0] sec,
         input logic tx, input logic exp);
      acc(2'h3, 1'b1, {32'h0, f}, 3'h0, 64'h0, 1'b1);
      cur_el <= el;
      cur_sec <= sec;
      in_transaction <= tx;
      repeat (3) @(posedge clk_sys);
      #1 chk(64'(count_enable), 64'(exp));
   endtask : ce

   initial begin
      repeat (20) @(posedge clk_sys);
      reset_n <= 1'b1;
      acc(2'h3, 1'b0, 64'h0, 3'h0, 64'h0, 1'b1);
      acc(2'h3, 1'b1, '1, 3'h0, 64'h0, 1'b1);
      acc(2'h3, 1'b0, 64'h0, 3'h0, 64'hfdf0_0000, 1'b1);
      chk(64'(alt_rdata), 64'hfdf0_0000);
      sel2_enabled <= 1'b0;
      acc(2'h3, 1'b0, 64'h0, 3'h0, 64'hfcf0_0000, 1'b1);
      sel2_enabled <= 1'b1;
      @(posedge clk_sys);
      alt_write <= 1'b1;
      alt_wdata <= 32'h1234_5678;
      @(posedge clk_sys);
      alt_write <= 1'b0;
      acc(2'h3, 1'b0, 64'h0, 3'h0, 64'h1030_0000, 1'b1);
      sys_op2 <= 3'h0;
      acc(2'h3, 1'b0, 64'h0, 3'h0, 64'h0, 1'b0);
      sys_window <= 1'b1;
      counter_selector_field <= 5'h1e;
      acc(2'h3, 1'b0, 64'h0, 3'h0, 64'h0, 1'b0);
      counter_selector_field <= CCF_SEL_CYCLE;
      acc(2'h3, 1'b0, 64'h0, 3'h0, 64'h1030_0000, 1'b1);
      sys_window <= 1'b0;
      sys_op2 <= CCF_OP2;
      $display("test access views done");
      user_access_enable_bit <= 1'b0;
      acc(2'h0, 1'b0, 64'h0, 3'h2, 64'h0, 1'b1);
      host_trap_general_bit <= 1'b1;
      acc(2'h0, 1'b0, 64'h0, 3'h3, 64'h0, 1'b1);
      user_access_enable_bit <= 1'b1;
      host_el2_bit <= 1'b1;
      fine_grained_read_trap <= 1'b1;
      acc(2'h0, 1'b0, 64'h0, 3'h0, 64'h1030_0000, 1'b1);
      acc(2'h1, 1'b0, 64'h0, 3'h3, 64'h0, 1'b1);
      fine_grained_read_trap <= 1'b0;
      fine_grained_write_trap <= 1'b1;
      acc(2'h1, 1'b0, 64'h0, 3'h0, 64'h1030_0000, 1'b1);
      acc(2'h1, 1'b1, 64'h0, 3'h3, 64'h0, 1'b1);
      acc(2'h3, 1'b0, 64'h0, 3'h0, 64'h1030_0000, 1'b1);
      fine_grained_trap_permit <= 1'b0;
      acc(2'h1, 1'b1, 64'h0, 3'h0, 64'h0, 1'b1);
      el2_monitor_trap_bit <= 1'b1;
      el2_enabled <= 1'b0;
      acc(2'h1, 1'b0, 64'h0, 3'h0, 64'h0, 1'b1);
      el2_enabled <= 1'b1;
      acc(2'h1, 1'b0, 64'h0, 3'h3, 64'h0, 1'b1);
      acc(2'h2, 1'b0, 64'h0, 3'h0, 64'h0, 1'b1);
      el3_monitor_trap_bit <= 1'b1;
      acc(2'h2, 1'b0, 64'h0, 3'h4, 64'h0, 1'b1);
      halted <= 1'b1;
      secure_debug_disabled <= 1'b1;
      acc(2'h1, 1'b0, 64'h0, 3'h1, 64'h0, 1'b1);
      acc(2'h3, 1'b0, 64'h0, 3'h0, 64'h0, 1'b1);
      halted <= 1'b0;
      el3_monitor_trap_bit <= 1'b0;
      el2_monitor_trap_bit <= 1'b0;
      $display("test trap routing done");
      ce(32'h0, 2'h1, 2'h1, 1'b1, 1'b1);
      ce(32'h8000_0000, 2'h1, 2'h1, 1'b1, 1'b0);
      ce(32'h8000_0000, 2'h1, 2'h0, 1'b1, 1'b0);
      ce(32'ha000_0000, 2'h1, 2'h1, 1'b1, 1'b1);
      ce(32'h4000_0000, 2'h0, 2'h0, 1'b1, 1'b0);
      ce(32'h4000_0000, 2'h0, 2'h1, 1'b1, 1'b0);
      ce(32'h5000_0000, 2'h0, 2'h1, 1'b1, 1'b1);
      ce(32'h0800_0000, 2'h2, 2'h1, 1'b1, 1'b1);
      ce(32'h0, 2'h2, 2'h1, 1'b1, 1'b0);
      ce(32'h0, 2'h3, 2'h0, 1'b1, 1'b1);
      ce(32'h0400_0000, 2'h3, 2'h0, 1'b1, 1'b0);
      ce(32'h0100_0000, 2'h2, 2'h0, 1'b1, 1'b1);
      ce(32'h0900_0000, 2'h2, 2'h0, 1'b1, 1'b0);
      ce(32'h0080_0000, 2'h1, 2'h1, 1'b0, 1'b0);
      ce(32'h0080_0000, 2'h1, 2'h1, 1'b1, 1'b1);
      ce(32'h0040_0000, 2'h1, 2'h2, 1'b1, 1'b0);
      ce(32'h8040_0000, 2'h1, 2'h2, 1'b1, 1'b1);
      ce(32'h0020_0000, 2'h0, 2'h2, 1'b1, 1'b0);
      ce(32'h0010_0000, 2'h2, 2'h2, 1'b1, 1'b1);
      ce(32'h0, 2'h2, 2'h2, 1'b1, 1'b0);
      $display("test count qualification done");
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
